// ### hdl/cisd_core.sv
// Overview of operation
// - Software trap pushes PC low, PC high, X, A, flags; masks; vectors; 9 cycles
// - Wait clears the mask and halts the core until an interrupt
// - Test sets N and Z from A, X or memory, clears V
// - Stack offset modes add offset to stack pointer, after a prefix byte
// - Extended mode fetches address high byte then low byte
// - 16-bit indexed offset fetched high then low, added to index pair
// - Direct-to-direct move copies source byte to destination address
// - Direct-to-indexed move writes at index pair, then increments it
// - Indexed-to-direct move reads at index pair, stores, then increments
// - Immediate-to-direct move writes the immediate byte to destination
// - Offset indexed post-increment uses pair plus offset, then increments
// - Direct branch forms carry address then signed offset added if taken
`timescale 1ns/10ps
`default_nettype none
module cisd_core import cisd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Memory bus, read data combinational from the address
    output var cisd_bus_s mem_bus_q,
    input wire logic [7:0] mem_rdata,
    // Wake from wait
    input wire logic irq_req,
    output logic halted_q,
    // Programmer-visible registers
    output logic [15:0] pc_q,
    output logic [15:0] stackptr_q,
    output logic [7:0] acc_q,
    output logic [7:0] index_low_q,
    output logic [7:0] index_high_q,
    output logic [7:0] condition_flags_q
);
    cisd_state_e st_q, st_d;
    cisd_mode_e mode_q, mode_d;
    cisd_kind_e kind_q, kind_d;
    cisd_dec_s dec;
    cisd_bus_s bus_d;
    logic [7:0] op_q, op_d, t_q, t_d, acc_d, xl_d, xh_d, flags_d, nzv_val;
    logic [7:0] nzv_flags, push_byte;
    logic [15:0] pc_d, sp_d, ea_q, ea_d, ea_addr, hx;
    logic [2:0] cnt_q, cnt_d;
    logic pre_q, pre_d, halt_d, bit_val;

    assign hx = {index_high_q, index_low_q};

    cisd_ea u_ea (
        .mode(mode_q),
        .hx(hx),
        .sp(stackptr_q),
        .hi(t_q),
        .lo(mem_rdata),
        .wide(st_q == ST_OPB2),
        .addr(ea_addr)
    );

    assign nzv_val = (st_q == ST_FETCH) ?
        ((mem_rdata == OP_TSTX) ? index_low_q : acc_q) :
        ((st_q == ST_WR) ? t_q : mem_rdata);

    cisd_nzv u_nzv (
        .val(nzv_val),
        .flags_in(condition_flags_q),
        .flags_out(nzv_flags)
    );

    always_comb begin
        dec = cisd_decode(pre_q, mem_rdata);
        st_d = st_q;
        mode_d = mode_q;
        kind_d = kind_q;
        op_d = op_q;
        pre_d = pre_q;
        t_d = t_q;
        ea_d = ea_q;
        cnt_d = cnt_q;
        pc_d = pc_q;
        sp_d = stackptr_q;
        acc_d = acc_q;
        xl_d = index_low_q;
        xh_d = index_high_q;
        flags_d = condition_flags_q;
        halt_d = halted_q;
        bit_val = mem_rdata[op_q[3:1]];
        case (st_q)
            ST_FETCH: begin
                pc_d = pc_q + 16'h0001;
                if (!pre_q && mem_rdata == OP_PREFIX) begin
                    pre_d = 1'b1;
                end else begin
                    pre_d = 1'b0;
                    op_d = mem_rdata;
                    mode_d = dec.mode;
                    kind_d = dec.kind;
                    case (dec.kind)
                        KD_XFER: begin
                            case (mem_rdata)
                                OP_TAP: begin
                                    flags_d = acc_q | CCR_FIXED;
                                    st_d = ST_IDLE;
                                end
                                OP_TPA: acc_d = condition_flags_q;
                                OP_TAX: xl_d = acc_q;
                                OP_TXA: acc_d = index_low_q;
                                OP_TSX: begin
                                    {xh_d, xl_d} = stackptr_q + 16'h0001;
                                    st_d = ST_IDLE;
                                end
                                OP_TXS: begin
                                    sp_d = hx - 16'h0001;
                                    st_d = ST_IDLE;
                                end
                                default: st_d = ST_FETCH;
                            endcase
                        end
                        KD_TSTR: flags_d = nzv_flags;
                        KD_SWI: begin
                            cnt_d = 3'h0;
                            st_d = ST_PUSH;
                        end
                        KD_WAIT: begin
                            flags_d[CCR_I] = 1'b0;
                            halt_d = 1'b1;
                            st_d = ST_HALT;
                        end
                        KD_NOP: st_d = ST_FETCH;
                        default: begin
                            if (dec.mode == MD_IX || dec.mode == MD_IXPD) begin
                                ea_d = hx;
                                st_d = ST_RD;
                            end else begin
                                st_d = ST_OPB1;
                            end
                        end
                    endcase
                end
            end
            ST_OPB1: begin
                pc_d = pc_q + 16'h0001;
                case (mode_q)
                    MD_IMM: begin
                        acc_d = mem_rdata;
                        flags_d = nzv_flags;
                        st_d = ST_FETCH;
                    end
                    MD_IMD: begin
                        t_d = mem_rdata;
                        st_d = ST_DST;
                    end
                    MD_EXT, MD_IX2, MD_SP2: begin
                        t_d = mem_rdata;
                        st_d = ST_OPB2;
                    end
                    MD_IX1, MD_SP1, MD_IX1P: begin
                        ea_d = ea_addr;
                        st_d = ST_RD;
                    end
                    default: begin
                        ea_d = {8'h00, mem_rdata};
                        st_d = ST_RD;
                    end
                endcase
            end
            ST_OPB2: begin
                pc_d = pc_q + 16'h0001;
                ea_d = ea_addr;
                st_d = ST_RD;
            end
            ST_RD: begin
                st_d = ST_FETCH;
                case (kind_q)
                    KD_LDA: begin
                        acc_d = mem_rdata;
                        flags_d = nzv_flags;
                    end
                    KD_TST: flags_d = nzv_flags;
                    KD_CBEQ: begin
                        t_d = {7'h00, acc_q == mem_rdata};
                        {xh_d, xl_d} = hx + 16'h0001;
                        st_d = ST_REL;
                    end
                    KD_BRBIT: begin
                        flags_d[CCR_C] = bit_val;
                        t_d = {7'h00, bit_val ^ op_q[0]};
                        st_d = ST_REL;
                    end
                    KD_MOV: begin
                        t_d = mem_rdata;
                        if (mode_q == MD_DIXP) begin
                            ea_d = hx;
                            st_d = ST_WR;
                        end else begin
                            st_d = ST_DST;
                        end
                    end
                    default: st_d = ST_FETCH;
                endcase
            end
            ST_DST: begin
                pc_d = pc_q + 16'h0001;
                ea_d = {8'h00, mem_rdata};
                st_d = ST_WR;
            end
            ST_WR: begin
                flags_d = nzv_flags;
                if (mode_q == MD_DIXP || mode_q == MD_IXPD) begin
                    {xh_d, xl_d} = hx + 16'h0001;
                end
                st_d = ST_FETCH;
            end
            ST_REL: begin
                // Taken offset is relative to the address after the offset byte
                pc_d = pc_q + 16'h0001 + (t_q[0] ?
                    {{8{mem_rdata[7]}}, mem_rdata} : 16'h0000);
                st_d = ST_FETCH;
            end
            ST_PUSH: begin
                sp_d = stackptr_q - 16'h0001;
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == PUSH_LAST) begin
                    flags_d[CCR_I] = 1'b1;
                    st_d = ST_VECH;
                end
            end
            ST_VECH: begin
                pc_d[15:8] = mem_rdata;
                st_d = ST_VECL;
            end
            ST_VECL: begin
                pc_d[7:0] = mem_rdata;
                st_d = ST_IDLE;
            end
            ST_IDLE: st_d = ST_FETCH;
            ST_HALT: begin
                // Core stays frozen, bus idle, until the wake request
                if (irq_req) begin
                    halt_d = 1'b0;
                    st_d = ST_FETCH;
                end
            end
            default: st_d = ST_FETCH;
        endcase
        case (cnt_d)
            3'h0: push_byte = pc_d[7:0];
            3'h1: push_byte = pc_d[15:8];
            3'h2: push_byte = xl_d;
            3'h3: push_byte = acc_d;
            default: push_byte = flags_d;
        endcase
        bus_d = BUS_IDLE;
        case (st_d)
            ST_FETCH, ST_OPB1, ST_OPB2, ST_DST, ST_REL: begin
                bus_d.addr = pc_d;
                bus_d.rd = 1'b1;
            end
            ST_RD: begin
                bus_d.addr = ea_d;
                bus_d.rd = 1'b1;
            end
            ST_WR: begin
                bus_d.addr = ea_d;
                bus_d.wr = 1'b1;
                bus_d.wdata = t_d;
            end
            ST_PUSH: begin
                bus_d.addr = sp_d;
                bus_d.wr = 1'b1;
                bus_d.wdata = push_byte;
            end
            ST_VECH: begin
                bus_d.addr = VEC_HI;
                bus_d.rd = 1'b1;
            end
            ST_VECL: begin
                bus_d.addr = VEC_LO;
                bus_d.rd = 1'b1;
            end
            default: bus_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_FETCH;
            mode_q <= MD_NONE;
            kind_q <= KD_NOP;
            op_q <= 8'h00;
            pre_q <= 1'b0;
            t_q <= 8'h00;
            ea_q <= 16'h0000;
            cnt_q <= 3'h0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            kind_q <= kind_d;
            op_q <= op_d;
            pre_q <= pre_d;
            t_q <= t_d;
            ea_q <= ea_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= PC_RESET;
            stackptr_q <= SP_RESET;
            acc_q <= 8'h00;
            index_low_q <= 8'h00;
            index_high_q <= 8'h00;
            condition_flags_q <= CCR_RESET;
        end else begin
            pc_q <= pc_d;
            stackptr_q <= sp_d;
            acc_q <= acc_d;
            index_low_q <= xl_d;
            index_high_q <= xh_d;
            condition_flags_q <= flags_d;
        end
    end

    // First access after reset is the opcode read at the reset address
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_bus_q <= '{PC_RESET, 1'b1, 1'b0, 8'h00};
            halted_q <= 1'b0;
        end else begin
            mem_bus_q <= bus_d;
            halted_q <= halt_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    swi_sequence_a: assert property (
        (st_q == ST_FETCH && !pre_q && mem_rdata == OP_SWI) |=>
        mem_bus_q.wr [*5] ##1 (mem_bus_q.addr == VEC_HI)
        ##1 (mem_bus_q.addr == VEC_LO) ##2 (st_q == ST_FETCH))
        else $error("software trap sequence wrong");
    swi_mask_a: assert property (
        (st_q == ST_VECH) |-> condition_flags_q[CCR_I])
        else $error("mask not set before vector fetch");
    wait_halt_a: assert property (
        (st_q == ST_FETCH && !pre_q && mem_rdata == OP_WAIT) |=>
        (halted_q && !condition_flags_q[CCR_I] && !mem_bus_q.rd))
        else $error("wait did not halt");
    tst_flags_a: assert property (
        (st_q == ST_FETCH && !pre_q && mem_rdata == OP_TSTA) |=>
        (condition_flags_q[CCR_N] == $past(acc_q[7])
        && condition_flags_q[CCR_Z] == ($past(acc_q) == 8'h00)
        && !condition_flags_q[CCR_V]
        && condition_flags_q[CCR_C] == $past(condition_flags_q[CCR_C])))
        else $error("test flags wrong");
    sp_offset_a: assert property (
        (st_q == ST_OPB1 && mode_q == MD_SP1) |=>
        (mem_bus_q.addr == 16'($past(stackptr_q) + $past(mem_rdata))))
        else $error("stack offset address wrong");
    ext_addr_a: assert property (
        (st_q == ST_OPB2 && mode_q == MD_EXT) |=>
        (mem_bus_q.addr == {$past(t_q), $past(mem_rdata)}))
        else $error("extended address wrong");
    ix2_addr_a: assert property (
        (st_q == ST_OPB2 && mode_q == MD_IX2) |=>
        (mem_bus_q.addr == 16'($past(hx) + {$past(t_q), $past(mem_rdata)})))
        else $error("indexed 16-bit address wrong");
    mov_write_a: assert property (
        (st_q == ST_RD && kind_q == KD_MOV && mode_q == MD_DD) |=>
        ##1 (mem_bus_q.wr && mem_bus_q.wdata == $past(mem_rdata, 2)))
        else $error("move data not copied");
    post_inc_a: assert property (
        (st_q == ST_WR && (mode_q == MD_DIXP || mode_q == MD_IXPD)) |=>
        (hx == 16'($past(hx) + 16'h0001)))
        else $error("index pair not incremented");
    xfer_flags_a: assert property (
        (st_q == ST_FETCH && !pre_q && mem_rdata == OP_TAX) |=>
        (condition_flags_q == $past(condition_flags_q)
        && index_low_q == $past(acc_q)))
        else $error("transfer changed flags");

    swi_seen_c: cover property (st_q == ST_VECL);
    wake_seen_c: cover property (halted_q ##1 !halted_q);
    branch_taken_c: cover property (st_q == ST_REL && t_q[0]);
endmodule : cisd_core
`default_nettype wire

// ### hdl/cisd_pkg.sv
package cisd_pkg;

    localparam logic [7:0] OP_SWI = 8'h83;
    localparam logic [7:0] OP_TAP = 8'h84;
    localparam logic [7:0] OP_TPA = 8'h85;
    localparam logic [7:0] OP_TXS = 8'h94;
    localparam logic [7:0] OP_TSX = 8'h95;
    localparam logic [7:0] OP_TAX = 8'h97;
    localparam logic [7:0] OP_TXA = 8'h9f;
    localparam logic [7:0] OP_WAIT = 8'h8f;
    localparam logic [7:0] OP_PREFIX = 8'h9e;
    localparam logic [7:0] OP_TSTA = 8'h4d;
    localparam logic [7:0] OP_TSTX = 8'h5d;

    localparam int CCR_V = 7;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h68;
    localparam logic [7:0] CCR_FIXED = 8'h60;

    localparam logic [15:0] PC_RESET = 16'hc000;
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [15:0] VEC_HI = 16'hfffc;
    localparam logic [15:0] VEC_LO = 16'hfffd;
    localparam logic [2:0] PUSH_LAST = 3'h4;
    localparam int SWI_CYCLES = 9;

    typedef enum logic [3:0] {
        ST_FETCH = 4'b0000,
        ST_OPB1 = 4'b0001,
        ST_OPB2 = 4'b0010,
        ST_RD = 4'b0011,
        ST_DST = 4'b0100,
        ST_WR = 4'b0101,
        ST_REL = 4'b0110,
        ST_PUSH = 4'b0111,
        ST_VECH = 4'b1000,
        ST_VECL = 4'b1001,
        ST_IDLE = 4'b1010,
        ST_HALT = 4'b1011
    } cisd_state_e;

    typedef enum logic [3:0] {
        MD_NONE = 4'b0000,
        MD_IMM = 4'b0001,
        MD_DIR = 4'b0010,
        MD_EXT = 4'b0011,
        MD_IX = 4'b0100,
        MD_IX1 = 4'b0101,
        MD_IX2 = 4'b0110,
        MD_SP1 = 4'b0111,
        MD_SP2 = 4'b1000,
        MD_IX1P = 4'b1001,
        MD_DD = 4'b1010,
        MD_DIXP = 4'b1011,
        MD_IMD = 4'b1100,
        MD_IXPD = 4'b1101,
        MD_DREL = 4'b1110
    } cisd_mode_e;

    typedef enum logic [3:0] {
        KD_NOP = 4'b0000,
        KD_XFER = 4'b0001,
        KD_TSTR = 4'b0010,
        KD_TST = 4'b0011,
        KD_LDA = 4'b0100,
        KD_MOV = 4'b0101,
        KD_CBEQ = 4'b0110,
        KD_BRBIT = 4'b0111,
        KD_SWI = 4'b1000,
        KD_WAIT = 4'b1001
    } cisd_kind_e;

    typedef struct packed {
        cisd_kind_e kind;
        cisd_mode_e mode;
    } cisd_dec_s;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cisd_bus_s;

    localparam cisd_bus_s BUS_IDLE = '{16'h0000, 1'b0, 1'b0, 8'h00};

    function automatic cisd_dec_s cisd_decode(input logic pre,
                                              input logic [7:0] op);
        cisd_dec_s d;
        d = '{KD_NOP, MD_NONE};
        if (pre) begin
            case (op)
                8'h6d: d = '{KD_TST, MD_SP1};
                8'he6: d = '{KD_LDA, MD_SP1};
                8'hd6: d = '{KD_LDA, MD_SP2};
                default: d = '{KD_NOP, MD_NONE};
            endcase
        end else begin
            casez (op)
                8'h0?: d = '{KD_BRBIT, MD_DREL};
                8'h3d: d = '{KD_TST, MD_DIR};
                8'h6d: d = '{KD_TST, MD_IX1};
                8'h7d: d = '{KD_TST, MD_IX};
                8'h4d, 8'h5d: d = '{KD_TSTR, MD_NONE};
                8'h4e: d = '{KD_MOV, MD_DD};
                8'h5e: d = '{KD_MOV, MD_DIXP};
                8'h6e: d = '{KD_MOV, MD_IMD};
                8'h7e: d = '{KD_MOV, MD_IXPD};
                8'h61: d = '{KD_CBEQ, MD_IX1P};
                8'ha6: d = '{KD_LDA, MD_IMM};
                8'hb6: d = '{KD_LDA, MD_DIR};
                8'hc6: d = '{KD_LDA, MD_EXT};
                8'hd6: d = '{KD_LDA, MD_IX2};
                8'he6: d = '{KD_LDA, MD_IX1};
                8'hf6: d = '{KD_LDA, MD_IX};
                8'h83: d = '{KD_SWI, MD_NONE};
                8'h8f: d = '{KD_WAIT, MD_NONE};
                8'h84, 8'h85, 8'h94, 8'h95, 8'h97, 8'h9f:
                    d = '{KD_XFER, MD_NONE};
                default: d = '{KD_NOP, MD_NONE};
            endcase
        end
        return d;
    endfunction : cisd_decode

endpackage : cisd_pkg

// ### hdl/cisd_ea.sv
`timescale 1ns/10ps
`default_nettype none
module cisd_ea import cisd_pkg::*; (
    // Addressing mode and bases
    input wire cisd_mode_e mode,
    input wire logic [15:0] hx,
    input wire logic [15:0] sp,
    // Offset bytes
    input wire logic [7:0] hi,
    input wire logic [7:0] lo,
    input wire logic wide,
    // Result
    output logic [15:0] addr
);
    logic [15:0] base;
    logic [15:0] off;

    // High byte first, low byte second
    assign off = wide ? {hi, lo} : {8'h00, lo};
    always_comb begin
        case (mode)
            MD_EXT: base = 16'h0000;
            MD_SP1, MD_SP2: base = sp;
            default: base = hx;
        endcase
    end
    assign addr = base + off;
endmodule : cisd_ea
`default_nettype wire

// ### hdl/cisd_nzv.sv
`timescale 1ns/10ps
`default_nettype none
module cisd_nzv import cisd_pkg::*; (
    // Tested value and current flags
    input wire logic [7:0] val,
    input wire logic [7:0] flags_in,
    // Updated flags
    output logic [7:0] flags_out
);
    // Only N, Z and V move; H, I and C pass through
    always_comb begin
        flags_out = flags_in;
        flags_out[CCR_V] = 1'b0;
        flags_out[CCR_N] = val[7];
        flags_out[CCR_Z] = (val == 8'h00);
    end
endmodule : cisd_nzv
`default_nettype wire

// ### verif/cisd_mem.sv
`timescale 1ns/10ps
`default_nettype none
module cisd_mem import cisd_pkg::*; (
    // Clock and core bus
    input wire logic sys_clk,
    input wire cisd_bus_s bus,
    output logic [7:0] rdata,
    // Bench loading port
    input wire logic ld_en,
    input wire logic [15:0] ld_addr,
    input wire logic [7:0] ld_data
);
    logic [7:0] mem [0:65535];
    // Off-cycle data is inverted so a read without rd cannot pass by luck
    assign rdata = bus.rd ? mem[bus.addr] : ~mem[bus.addr];
    always_ff @(posedge sys_clk) begin
        if (ld_en) begin
            mem[ld_addr] <= ld_data;
        end else if (bus.wr) begin
            mem[bus.addr] <= bus.wdata;
        end
    end
endmodule : cisd_mem
`default_nettype wire

// ### verif/cpu_instruction_subset_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module cpu_instruction_subset_decode_tb import cisd_pkg::*;;
    logic sys_clk, rstn, irq_req, halted_q, ld_en, woke;
    cisd_bus_s mem_bus_q;
    logic [7:0] mem_rdata, acc_q, index_low_q, index_high_q, flags, ld_data;
    logic [7:0] r, r2, r3, r4, r5;
    logic [15:0] pc_q, stackptr_q, ld_addr;
    logic [23:0] exp_q [$];
    int error_cnt, tests_run, cyc, t0;
    cisd_core i_cisd_core (.sys_clk(sys_clk), .rstn(rstn),
        .mem_bus_q(mem_bus_q), .mem_rdata(mem_rdata), .irq_req(irq_req),
        .halted_q(halted_q), .pc_q(pc_q), .stackptr_q(stackptr_q),
        .acc_q(acc_q), .index_low_q(index_low_q),
        .index_high_q(index_high_q), .condition_flags_q(flags));
    cisd_mem i_cisd_mem (.sys_clk(sys_clk), .bus(mem_bus_q),
        .rdata(mem_rdata), .ld_en(ld_en), .ld_addr(ld_addr),
        .ld_data(ld_data));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Flags after a load or test from reset state, I given
    function automatic logic [7:0] fl(input logic [7:0] v, input logic i);
        return {3'b011, 1'b0, i, v[7], v == 8'h00, 1'b0};
    endfunction : fl
    always @(posedge sys_clk) begin
        cyc++;
        if (rstn && mem_bus_q.wr) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("FAIL %0t unexpected write", $time);
            end else `CHK({mem_bus_q.addr, mem_bus_q.wdata}, exp_q.pop_front())
        end
        if (rstn && mem_bus_q.rd && mem_bus_q.addr == 16'hc002) t0 = cyc;
        if (rstn && mem_bus_q.rd && mem_bus_q.addr == 16'h1234) `CHK(cyc - t0, 9)
        if (rstn && mem_bus_q.rd && mem_bus_q.addr == 16'h1235) woke = 1'b1;
    end
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
    endtask : put
    task automatic prog(input logic [7:0] b[]);
        @(posedge sys_clk);
        rstn <= 1'b0;
        foreach (b[i]) put(16'hc000 + 16'(i), b[i]);
    endtask : prog
    // Reset stays low while the code loads, so no fetch sees a half image
    task automatic run();
        repeat (20) @(posedge sys_clk);
        ld_en <= 1'b0;
        rstn <= 1'b1;
        repeat (40) @(posedge sys_clk);
        `CHK(exp_q.size(), 0)
    endtask : run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        irq_req = 1'b0;
        ld_en = 1'b0;
        ld_addr = 16'h0000;
        ld_data = 8'h00;
        woke = 1'b0;
        void'($urandom(32'hb747367e));
        r = 8'($urandom());
        prog('{8'ha6, r, 8'h83});
        put(16'hfffc, 8'h12);
        put(16'hfffd, 8'h34);
        put(16'h1234, 8'h8f);
        put(16'h1235, 8'h8f);
        exp_q = '{{16'h00ff, 8'h03}, {16'h00fe, 8'hc0}, {16'h00fd, 8'h00},
                  {16'h00fc, r}, {16'h00fb, fl(r, 1'b1)}};
        run();
        `CHK(halted_q, 1'b1)
        `CHK(stackptr_q, 16'h00fa)
        `CHK(flags, fl(r, 1'b0))
        irq_req <= 1'b1;
        @(posedge sys_clk);
        irq_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK(woke, 1'b1)
        `CHK(halted_q, 1'b1)
        $display("test trap_and_wait done");
        r = 8'($urandom());
        prog('{8'h6e, r, 8'h40, 8'h4e, 8'h40, 8'h41, 8'h3d, 8'h41, 8'h8f});
        exp_q = '{{16'h0040, r}, {16'h0041, r}};
        run();
        `CHK(flags, fl(r, 1'b0))
        $display("test direct_moves done");
        r = 8'($urandom());
        prog('{8'ha6, r, 8'h84, 8'h85, 8'h95, 8'h94, 8'h4d, 8'h8f});
        run();
        `CHK(acc_q, r | 8'h60)
        `CHK({index_high_q, index_low_q}, 16'h0100)
        `CHK(stackptr_q, 16'h00ff)
        `CHK(flags, ((r | 8'h60) & 8'h71) | {5'h00, r[7], 2'b00})
        $display("test transfers done");
        r = 8'($urandom());
        r2 = 8'($urandom());
        r3 = 8'($urandom());
        r4 = 8'($urandom());
        r5 = 8'($urandom());
        prog('{8'h5e, 8'h40, 8'h7e, 8'h50, 8'hd6, 8'h01, 8'h00, 8'h97,
               8'hc6, 8'h02, 8'h34, 8'h9e, 8'h6d, 8'hff, 8'h8f});
        put(16'h0040, r);
        put(16'h0001, r2);
        put(16'h0102, r5);
        put(16'h0234, r4);
        put(16'h01fe, r3);
        exp_q = '{{16'h0000, r}, {16'h0050, r2}};
        run();
        `CHK(index_low_q, r5)
        `CHK(index_high_q, 8'h00)
        `CHK(acc_q, r4)
        `CHK(flags, fl(r3, 1'b0))
        $display("test indexed_modes done");
        r = 8'($urandom());
        prog('{8'ha6, r, 8'h61, 8'h00, 8'h02, 8'h8f, 8'h8f, 8'h00, 8'h41,
               8'h02, 8'h8f, 8'h8f, 8'h8f});
        put(16'h0000, r);
        put(16'h0041, 8'h01);
        run();
        `CHK(pc_q, 16'hc00d)
        `CHK({index_high_q, index_low_q}, 16'h0001)
        `CHK(flags, fl(r, 1'b0) | 8'h01)
        $display("test branches done");
        report_and_stop();
    end
endmodule : cpu_instruction_subset_decode_tb
`default_nettype wire
